/* common/riar_consts.svh */
// register offsets, field positions and reset values of the alias remap block
`ifndef RIAR_CONSTS_SVH
`define RIAR_CONSTS_SVH
// physical-address slot 0 sits one below slot 1 at 0x5e
`define RIAR_PHYS_BASE 8'h5d
`define RIAR_ALIAS_BASE 8'h65
`define RIAR_REMOTE_PHYS_ADDR_SLOT5 8'h62
`define RIAR_REMOTE_PHYS_ADDR_SLOT6 8'h63
`define RIAR_REMOTE_PHYS_ADDR_SLOT7 8'h64
`define RIAR_REMOTE_ALIAS_SLOT0 8'h65
`define RIAR_REMOTE_ALIAS_SLOT1 8'h66
`define RIAR_REMOTE_ALIAS_SLOT2 8'h67
// port-select register lives outside this block; its value arrives on a port
`define RIAR_PORT_SEL_OFS 8'h4c
`define RIAR_ADDR_MSB 7
`define RIAR_ADDR_LSB 1
`define RIAR_AUTO_ACK_BIT 0
`define RIAR_REG_RESET 8'h00
`define RIAR_ADDR_RESET 7'h00
`endif

/* common/riar_pkg.sv */
// types shared by the alias remap block and its link-side end
package riar_pkg;
   // local transaction address phase as seen by the i2c target logic
   typedef struct packed {
      logic [6:0] addr;
      logic rd;
   } riar_req_t;
   // remapped transaction handed to the control channel
   typedef struct packed {
      logic [1:0] port;
      logic [6:0] addr;
      logic rd;
   } riar_fwd_t;
   // answer returned to the local controller
   typedef struct packed {
      logic hit;
      logic ack;
   } riar_rsp_t;
   // transaction sequencer states
   typedef enum logic [1:0] {
      RIAR_ST_IDLE = 2'b00,
      RIAR_ST_WAIT = 2'b01
   } riar_state_t;
endpackage

/* verilog/riar_link.sv */
// link-clock end: takes remapped transactions and returns the remote acknowledge
module riar_link (
   input wire logic i_link_clk,
   input wire logic i_link_rst_b,
   input wire logic i_req_tgl,
   input riar_pkg::riar_fwd_t i_fwd,
   input wire logic i_remote_ack_valid,
   input wire logic i_remote_ack,
   output logic o_fwd_valid,
   output riar_pkg::riar_fwd_t o_fwd,
   output logic o_rsp_tgl,
   output logic o_rsp_ack
);
   import riar_pkg::*;

   logic req_s1_q; // first stage, read only by the second
   logic req_s2_q;
   logic req_s3_q;
   logic req_seen_q; // last toggle level already acted on
   logic req_evt; // new request, counted once stages two and three agree
   logic busy_q; // waiting for the remote acknowledge
   logic fwd_valid_q;
   riar_fwd_t fwd_q;
   logic rsp_tgl_q;
   logic ack_q;

   // three-stage synchroniser for the request toggle
   always_ff @(posedge i_link_clk) begin
      if (!i_link_rst_b) begin
         req_s1_q <= 1'b0;
         req_s2_q <= 1'b0;
         req_s3_q <= 1'b0;
         req_seen_q <= 1'b0;
      end else begin
         req_s1_q <= i_req_tgl;
         req_s2_q <= req_s1_q;
         req_s3_q <= req_s2_q;
         if (req_evt) begin
            req_seen_q <= req_s3_q;
         end
      end
   end

   assign req_evt = (req_s2_q == req_s3_q) && (req_s3_q != req_seen_q);

   // capture the remapped word; the ref side holds it until we answer
   always_ff @(posedge i_link_clk) begin
      if (!i_link_rst_b) begin
         fwd_q <= '0;
         fwd_valid_q <= 1'b0;
      end else begin
         fwd_valid_q <= req_evt;
         if (req_evt) begin
            fwd_q <= i_fwd;
         end
      end
   end

   // wait for the remote answer, then hand it back by a toggle
   always_ff @(posedge i_link_clk) begin
      if (!i_link_rst_b) begin
         busy_q <= 1'b0;
         rsp_tgl_q <= 1'b0;
         ack_q <= 1'b0;
      end else if (req_evt) begin
         busy_q <= 1'b1;
      end else if (busy_q && i_remote_ack_valid) begin
         busy_q <= 1'b0;
         ack_q <= i_remote_ack; // R10
         rsp_tgl_q <= ~rsp_tgl_q;
      end
   end

   assign o_fwd_valid = fwd_valid_q;
   assign o_fwd = fwd_q;
   assign o_rsp_tgl = rsp_tgl_q;
   assign o_rsp_ack = ack_q;
endmodule

/* verilog/riar_top.sv */
// per-port i2c alias decode, physical-address remap and auto-acknowledge
`include "riar_consts.svh"

// Overview of operation
// (R1) each slot holds 7-bit physical address, bits 7:1
// (R2) matched alias replaced by physical address, forwarded
// (R3) incoming address compared with every alias field
// (R4) alias slot n uses physical slot n
// (R5) zero alias disables its slot entirely
// (R6) alias bit 0 enables auto-acknowledge of writes
// (R7) auto-acknowledge ignores lock and remote answer
// (R8) registers banked per port, chosen by port select
// (R9) all mapping registers reset to zero
// (R10) otherwise return the remote acknowledge unchanged
module riar_top #(
   parameter int NUM_PORTS = 4,
   parameter int NUM_SLOTS = 8
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   input wire logic i_link_clk,
   input wire logic i_link_rst_b,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic [1:0] i_reg_port,
   output logic [7:0] o_reg_rdata,
   output logic o_reg_valid,
   input wire logic i_req_valid,
   input riar_pkg::riar_req_t i_req,
   input wire logic [1:0] i_req_port,
   output logic o_req_ready,
   output logic o_rsp_valid,
   output riar_pkg::riar_rsp_t o_rsp,
   output logic o_fwd_valid,
   output riar_pkg::riar_fwd_t o_fwd,
   input wire logic i_remote_ack_valid,
   input wire logic i_remote_ack
);
   import riar_pkg::*;

   // register storage, one bank per receive port
   logic [6:0] phys_q [NUM_PORTS][NUM_SLOTS];
   logic [6:0] alias_q [NUM_PORTS][NUM_SLOTS];
   logic aack_q [NUM_PORTS][NUM_SLOTS];

   // register access decode
   logic [3:0] phys_dec; // {hit, slot}
   logic [3:0] alias_dec;
   logic wr_port_ok; // selected bank exists
   logic [7:0] rdata_q;
   logic rvalid_q;

   // transaction path
   riar_state_t state_q;
   logic accept; // request taken this cycle
   logic [NUM_SLOTS-1:0] slot_hit;
   logic hit_any;
   logic [2:0] hit_slot;
   logic [6:0] hit_phys;
   logic [6:0] hit_alias;
   logic hit_aack;
   riar_fwd_t fwd_hold_q; // held stable for the link side
   logic req_tgl_q;
   logic sent_q; // answer already given by auto-acknowledge
   logic rsp_valid_q;
   riar_rsp_t rsp_q;

   // response crossing from the link domain
   logic rsp_tgl_link;
   logic rsp_ack_link; // stable while the toggle is pending
   logic rsp_s1_q; // first stage, read only by the second
   logic rsp_s2_q;
   logic rsp_s3_q;
   logic rsp_seen_q;
   logic rsp_evt;

   // slot decode of a register offset, used for both banks and both directions
   function automatic logic [3:0] slot_dec(input logic [7:0] a, input logic [7:0] base);
      logic [7:0] d;
      d = a - base;
      slot_dec = {(a >= base) && (d < 8'h08), d[2:0]};
   endfunction

   assign phys_dec = slot_dec(i_reg_addr, `RIAR_PHYS_BASE);
   assign alias_dec = slot_dec(i_reg_addr, `RIAR_ALIAS_BASE);
   // a port select beyond the last bank reaches nothing
   assign wr_port_ok = ({30'h0, i_reg_port} < NUM_PORTS);

   // physical-address bank writes; bit 0 is reserved and not stored
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            for (int s = 0; s < NUM_SLOTS; s++) begin
               phys_q[p][s] <= `RIAR_ADDR_RESET; // R9
            end
         end
      end else if (i_reg_wr && phys_dec[3] && wr_port_ok) begin
         // R1 R8
         phys_q[i_reg_port][phys_dec[2:0]] <= i_reg_wdata[`RIAR_ADDR_MSB:`RIAR_ADDR_LSB];
      end
   end

   // alias bank writes: alias field plus auto-acknowledge enable
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            for (int s = 0; s < NUM_SLOTS; s++) begin
               alias_q[p][s] <= `RIAR_ADDR_RESET; // R9
               aack_q[p][s] <= 1'b0; // R9
            end
         end
      end else if (i_reg_wr && alias_dec[3] && wr_port_ok) begin
         // R8
         alias_q[i_reg_port][alias_dec[2:0]] <= i_reg_wdata[`RIAR_ADDR_MSB:`RIAR_ADDR_LSB];
         aack_q[i_reg_port][alias_dec[2:0]] <= i_reg_wdata[`RIAR_AUTO_ACK_BIT]; // R6
      end
   end

   // register reads, answered one cycle later; unmapped offsets read zero
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         rdata_q <= `RIAR_REG_RESET;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= i_reg_rd;
         if (i_reg_rd) begin
            if (!wr_port_ok) begin
               rdata_q <= `RIAR_REG_RESET;
            end else if (phys_dec[3]) begin
               // reserved bit 0 reads as zero
               rdata_q <= {phys_q[i_reg_port][phys_dec[2:0]], 1'b0}; // R1 R8
            end else if (alias_dec[3]) begin
               rdata_q <= {alias_q[i_reg_port][alias_dec[2:0]],
                           aack_q[i_reg_port][alias_dec[2:0]]}; // R8
            end else begin
               rdata_q <= `RIAR_REG_RESET;
            end
         end
      end
   end

   assign o_reg_rdata = rdata_q;
   assign o_reg_valid = rvalid_q;

   // per-slot alias comparators in the bank of the requesting port
   genvar gs;
   generate
      for (gs = 0; gs < NUM_SLOTS; gs++) begin : g_cmp
         // R3 R5
         assign slot_hit[gs] = (alias_q[i_req_port][gs] != `RIAR_ADDR_RESET) &&
                               (alias_q[i_req_port][gs] == i_req.addr);
      end
   endgenerate

   // lowest slot wins if software programmed the same alias twice
   always_comb begin
      hit_slot = 3'h0;
      for (int s = NUM_SLOTS - 1; s >= 0; s--) begin
         if (slot_hit[s]) begin
            hit_slot = s[2:0];
         end
      end
   end

   assign hit_any = |slot_hit;
   assign hit_phys = phys_q[i_req_port][hit_slot]; // R4
   assign hit_alias = alias_q[i_req_port][hit_slot];
   assign hit_aack = aack_q[i_req_port][hit_slot];
   assign o_req_ready = (state_q == RIAR_ST_IDLE);
   assign accept = i_req_valid && o_req_ready;

   // three-stage synchroniser for the link response toggle
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         rsp_s1_q <= 1'b0;
         rsp_s2_q <= 1'b0;
         rsp_s3_q <= 1'b0;
         rsp_seen_q <= 1'b0;
      end else begin
         rsp_s1_q <= rsp_tgl_link;
         rsp_s2_q <= rsp_s1_q;
         rsp_s3_q <= rsp_s2_q;
         if (rsp_evt) begin
            rsp_seen_q <= rsp_s3_q;
         end
      end
   end

   assign rsp_evt = (rsp_s2_q == rsp_s3_q) && (rsp_s3_q != rsp_seen_q);

   // transaction sequencer; one forwarded transaction in flight at a time
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         state_q <= RIAR_ST_IDLE;
         fwd_hold_q <= '0;
         req_tgl_q <= 1'b0;
         sent_q <= 1'b0;
      end else begin
         case (state_q)
            RIAR_ST_IDLE: begin
               if (accept && hit_any) begin
                  // R2 R4
                  fwd_hold_q <= '{port: i_req_port, addr: hit_phys, rd: i_req.rd};
                  req_tgl_q <= ~req_tgl_q;
                  sent_q <= !i_req.rd && hit_aack; // R6
                  state_q <= RIAR_ST_WAIT;
               end
            end
            RIAR_ST_WAIT: begin
               // the remote must answer; there is no timeout here
               if (rsp_evt) begin
                  state_q <= RIAR_ST_IDLE;
               end
            end
            default: begin
               state_q <= RIAR_ST_IDLE;
            end
         endcase
      end
   end

   // answers to the local controller, one-cycle pulse
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         rsp_valid_q <= 1'b0;
         rsp_q <= '0;
      end else begin
         rsp_valid_q <= 1'b0;
         if (accept && !hit_any) begin
            // not a remote target: no acknowledge from this block
            rsp_valid_q <= 1'b1;
            rsp_q <= '{hit: 1'b0, ack: 1'b0};
         end else if (accept && !i_req.rd && hit_aack) begin
            // R6 R7: acknowledge now, without waiting for the link
            rsp_valid_q <= 1'b1;
            rsp_q <= '{hit: 1'b1, ack: 1'b1};
         end else if ((state_q == RIAR_ST_WAIT) && rsp_evt && !sent_q) begin
            rsp_valid_q <= 1'b1;
            rsp_q <= '{hit: 1'b1, ack: rsp_ack_link}; // R10
         end
      end
   end

   assign o_rsp_valid = rsp_valid_q;
   assign o_rsp = rsp_q;

   // link-clock end of the control channel
   riar_link u_link (
      .i_link_clk(i_link_clk),
      .i_link_rst_b(i_link_rst_b),
      .i_req_tgl(req_tgl_q),
      .i_fwd(fwd_hold_q),
      .i_remote_ack_valid(i_remote_ack_valid),
      .i_remote_ack(i_remote_ack),
      .o_fwd_valid(o_fwd_valid),
      .o_fwd(o_fwd),
      .o_rsp_tgl(rsp_tgl_link),
      .o_rsp_ack(rsp_ack_link)
   );

   // helper: last alias bank write, for the bank write check
   logic chk_wr_q;
   logic [1:0] chk_port_q;
   logic [2:0] chk_slot_q;
   logic [6:0] chk_val_q;
   always_ff @(posedge i_ref_clk) begin
      chk_wr_q <= i_rst_b && i_reg_wr && alias_dec[3] && wr_port_ok;
      chk_port_q <= i_reg_port;
      chk_slot_q <= alias_dec[2:0];
      chk_val_q <= i_reg_wdata[7:1];
   end

   // no slot can match straight after reset
   reset_clear_a: assert property (@(posedge i_ref_clk) // R9
      !i_rst_b ##1 i_rst_b |-> !hit_any)
      else $error("alias matched right after reset");

   // a zero alias never matches
   zero_alias_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // R5
      hit_any |-> (hit_alias != 7'h00))
      else $error("match through a disabled slot");

   // the match really equals the incoming address
   match_cmp_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // R3
      accept && hit_any |-> (hit_alias == i_req.addr))
      else $error("match with a different alias");

   // forwarded address is the same slot's physical address
   remap_addr_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // R2
      accept && hit_any |=> (fwd_hold_q.addr == $past(hit_phys)) &&
                            (req_tgl_q != $past(req_tgl_q)))
      else $error("wrong remapped address");

   // auto-acknowledged write is answered at once
   auto_ack_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // R7
      accept && hit_any && !i_req.rd && hit_aack |=> o_rsp_valid && o_rsp.hit && o_rsp.ack)
      else $error("auto acknowledge missing");

   // the later link answer of an auto-acknowledged write is swallowed
   aack_once_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // R7
      (state_q == RIAR_ST_WAIT) && rsp_evt && sent_q |=> !o_rsp_valid)
      else $error("auto acknowledged write answered twice");

   // a forwarded transaction blocks further requests until its answer
   busy_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // R2
      accept && hit_any |=> !o_req_ready && (state_q == RIAR_ST_WAIT))
      else $error("ready stayed high while forwarding");

   // nothing is answered while reset is held
   reset_quiet_a: assert property (@(posedge i_ref_clk) // R9
      !i_rst_b |=> !o_rsp_valid && !o_reg_valid && o_req_ready)
      else $error("answer given during reset");

   // alias reads return the auto-acknowledge enable in bit 0
   alias_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // R6
      i_reg_rd && alias_dec[3] && wr_port_ok |=>
      o_reg_valid && (o_reg_rdata[0] == $past(aack_q[i_reg_port][alias_dec[2:0]])))
      else $error("auto acknowledge enable read wrong");

   // otherwise the remote answer is passed through
   remote_ack_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // R10
      (state_q == RIAR_ST_WAIT) && rsp_evt && !sent_q |=>
      o_rsp_valid && o_rsp.hit && (o_rsp.ack == $past(rsp_ack_link)))
      else $error("remote acknowledge not returned");

   // an alias bank write lands in the selected port's slot
   bank_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // R8
      chk_wr_q |-> (alias_q[chk_port_q][chk_slot_q] == chk_val_q))
      else $error("alias write went to the wrong bank");

   // physical reads show the reserved bit as zero, one cycle later
   phys_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // R1
      i_reg_rd && phys_dec[3] |=> o_reg_valid && (o_reg_rdata[0] == 1'b0))
      else $error("physical address read malformed");

   // a miss forwards nothing and is answered next cycle
   miss_rsp_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // R2
      accept && !hit_any |=> o_rsp_valid && !o_rsp.hit && $stable(req_tgl_q))
      else $error("miss was forwarded or unanswered");
endmodule

/* verif/riar_far_model.sv */
// far-side model: remote serializer answering forwarded transactions on the link clock
module riar_far_model (
   input wire logic i_link_clk,
   input wire logic i_link_rst_b,
   input wire logic i_fwd_valid,
   input wire logic [3:0] i_delay,
   input wire logic i_ack_val,
   output logic o_ack_valid,
   output logic o_ack
);
   logic busy_q; // a forwarded transaction awaits its answer
   logic [3:0] wait_q; // link cycles left before answering
   logic last_q; // last answer given, inverted while idle

   // answer after a chosen delay; between answers the line never shows a stale value
   always_ff @(posedge i_link_clk) begin
      if (!i_link_rst_b) begin
         busy_q <= 1'b0;
         wait_q <= 4'h0;
         last_q <= 1'b0;
         o_ack_valid <= 1'b0;
         o_ack <= 1'b0;
      end else begin
         o_ack_valid <= 1'b0;
         o_ack <= ~last_q;
         if (i_fwd_valid) begin
            // zero delay answers promptly, larger values stall the round trip
            busy_q <= 1'b1;
            wait_q <= i_delay;
         end else if (busy_q && wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
         end else if (busy_q) begin
            busy_q <= 1'b0;
            o_ack_valid <= 1'b1;
            o_ack <= i_ack_val;
            last_q <= i_ack_val;
         end
      end
   end
endmodule

/* verif/remote_i2c_alias_remap_tb.sv */
// self-checking bench for the per-port alias decode and remap block
`include "riar_consts.svh"
module remote_i2c_alias_remap_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import riar_pkg::*;
   logic ref_clk, rst_b, link_clk, link_rst_b; // clocks and resets
   logic reg_wr, reg_rd, reg_valid; // register strobes
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [1:0] reg_port, req_port;
   logic req_valid, req_ready, rsp_valid, fwd_valid, ack_valid, ack;
   riar_req_t req;
   riar_rsp_t rsp;
   riar_fwd_t fwd, fwd_seen; // last forwarded transaction seen on the link
   logic [3:0] far_delay; // far side answer delay
   logic far_ack; // far side answer value
   int n_mismatch = 0;
   int cmp_count = 0;
   int n_rsp = 0; // answer pulses seen
   int n_fwd = 0; // forward pulses seen

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // link clock is offset so its edges never line up with the main clock
   initial begin
      link_clk = 1'b0;
      #3.3;
      forever #6 link_clk = ~link_clk;
   end

   riar_top #(.NUM_PORTS(4), .NUM_SLOTS(8)) i_dut (
      .i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_link_clk(link_clk),
      .i_link_rst_b(link_rst_b), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
      .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_port(reg_port),
      .o_reg_rdata(reg_rdata), .o_reg_valid(reg_valid), .i_req_valid(req_valid),
      .i_req(req), .i_req_port(req_port), .o_req_ready(req_ready),
      .o_rsp_valid(rsp_valid), .o_rsp(rsp), .o_fwd_valid(fwd_valid), .o_fwd(fwd),
      .i_remote_ack_valid(ack_valid), .i_remote_ack(ack));

   riar_far_model i_far (
      .i_link_clk(link_clk), .i_link_rst_b(link_rst_b), .i_fwd_valid(fwd_valid),
      .i_delay(far_delay), .i_ack_val(far_ack), .o_ack_valid(ack_valid), .o_ack(ack));

   // count pulses so doubled or stretched answers show up
   always @(posedge ref_clk) if (rsp_valid === 1'b1) n_rsp++;
   always @(posedge link_clk) begin
      if (fwd_valid === 1'b1) begin
         n_fwd++;
         fwd_seen = fwd;
      end
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // one-cycle write strobe
   task automatic wr_reg(input logic [1:0] p, input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      reg_port = p;
      @(negedge ref_clk);
      reg_wr = 1'b0;
   endtask

   // one-cycle read strobe, data checked while valid stands one cycle later
   task automatic rd_reg(input logic [1:0] p, input logic [7:0] a, input logic [7:0] exp);
      @(negedge ref_clk);
      reg_rd = 1'b1;
      reg_addr = a;
      reg_port = p;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      chk("read valid", 16'h1, {15'h0, reg_valid});
      chk("read data", {8'h0, exp}, {8'h0, reg_rdata});
   endtask

   // one local transaction; returns cycles until the answer
   task automatic xact(input logic [1:0] p, input logic [6:0] a, input logic rd,
                       input logic [1:0] exp, output int lat);
      int k;
      int r0;
      r0 = n_rsp;
      @(negedge ref_clk);
      req_valid = 1'b1;
      req = '{addr: a, rd: rd};
      req_port = p;
      @(negedge ref_clk);
      req_valid = 1'b0;
      req = ~req;
      lat = 1;
      while (rsp_valid !== 1'b1 && lat < 300) begin
         @(negedge ref_clk);
         lat++;
      end
      chk("answer valid", 16'h1, {15'h0, rsp_valid});
      chk("answer", {14'h0, exp}, {14'h0, rsp});
      k = 0;
      while (req_ready !== 1'b1 && k < 300) begin
         @(negedge ref_clk);
         k++;
      end
      chk("ready back", 16'h1, {15'h0, req_ready});
      @(negedge ref_clk); // one rising edge so the pulse counter has seen any answer
      chk("answer count", 16'(r0 + 1), 16'(n_rsp));
   endtask

   // every mapping register of two banks reads zero after reset
   task automatic s_reset();
      for (int o = 0; o < 16; o++) begin
         rd_reg(2'd0, `RIAR_PHYS_BASE + 8'(o), 8'h00);
         rd_reg(2'd3, `RIAR_PHYS_BASE + 8'(o), 8'h00);
      end
   endtask

   // field widths, reserved bit, banking and an unmapped offset
   task automatic s_regs();
      wr_reg(2'd0, `RIAR_REMOTE_PHYS_ADDR_SLOT6, 8'ha5);
      rd_reg(2'd0, `RIAR_REMOTE_PHYS_ADDR_SLOT6, 8'ha4);
      wr_reg(2'd0, `RIAR_REMOTE_ALIAS_SLOT1, 8'h5b);
      rd_reg(2'd0, `RIAR_REMOTE_ALIAS_SLOT1, 8'h5b);
      rd_reg(2'd1, `RIAR_REMOTE_ALIAS_SLOT1, 8'h00);
      wr_reg(2'd0, `RIAR_PORT_SEL_OFS, 8'hff);
      rd_reg(2'd0, `RIAR_PORT_SEL_OFS, 8'h00);
   endtask

   // unclaimed addresses are answered at once and never forwarded
   task automatic s_miss();
      int lat;
      int f0;
      f0 = n_fwd;
      xact(2'd0, 7'h00, 1'b0, 2'b00, lat);
      xact(2'd2, 7'h2d, 1'b0, 2'b00, lat);
      repeat (20) @(negedge ref_clk);
      chk("miss forwards", 16'(f0), 16'(n_fwd));
   endtask

   // all eight slots remapped, remote answer relayed at both speeds
   task automatic s_remap();
      int lat;
      int f0;
      for (int n = 0; n < 8; n++) begin
         wr_reg(2'd3, `RIAR_PHYS_BASE + 8'(n), 8'h80 + 8'(2 * n));
         wr_reg(2'd3, `RIAR_ALIAS_BASE + 8'(n), 8'h20 + 8'(2 * n));
      end
      for (int n = 0; n < 8; n++) begin
         far_ack = n[0];
         far_delay = n[0] ? 4'h9 : 4'h0;
         f0 = n_fwd;
         xact(2'd3, 7'h10 + 7'(n), n[1], {1'b1, n[0]}, lat);
         chk("forward count", 16'(f0 + 1), 16'(n_fwd));
         chk("forward", 16'({2'd3, 7'h40 + 7'(n), n[1]}), 16'(fwd_seen));
      end
      // clearing an alias takes its slot out of decode
      wr_reg(2'd3, `RIAR_ALIAS_BASE + 8'h3, 8'h00);
      f0 = n_fwd;
      xact(2'd3, 7'h13, 1'b0, 2'b00, lat);
      repeat (20) @(negedge ref_clk);
      chk("cleared slot forwards", 16'(f0), 16'(n_fwd));
   endtask

   // auto-acknowledge answers writes at once even when the far side refuses
   task automatic s_aack();
      int lat;
      int f0;
      wr_reg(2'd0, `RIAR_PHYS_BASE + 8'h1, 8'h6e);
      far_ack = 1'b0;
      far_delay = 4'h9;
      f0 = n_fwd;
      xact(2'd0, 7'h2d, 1'b0, 2'b11, lat);
      chk("auto answer latency", 16'h1, {15'h0, lat <= 2});
      chk("forward", 16'({2'd0, 7'h37, 1'b0}), 16'(fwd_seen));
      chk("forward count", 16'(f0 + 1), 16'(n_fwd));
      xact(2'd0, 7'h2d, 1'b1, 2'b10, lat);
   endtask

   initial begin
      rst_b = 1'b0;
      link_rst_b = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_port = 2'd0;
      req_valid = 1'b0;
      req = '0;
      req_port = 2'd0;
      far_delay = 4'h0;
      far_ack = 1'b1;
      repeat (10) @(negedge ref_clk);
      link_rst_b = 1'b1;
      rst_b = 1'b1;
      s_reset();
      s_regs();
      s_miss();
      s_remap();
      s_aack();
      give_verdict();
   end

   // watchdog well beyond the few hundred cycles the run needs
   initial begin
      #100000;
      n_mismatch++;
      give_verdict();
   end
endmodule
